// ==== common/vwa_pkg.sv ====
// ***
// event arbiter constants
// ***
package vwa_pkg;
	localparam int NUM_EXT        = 5; // external trap inputs
	localparam int NUM_PROG       = 128; // programmable events
	localparam int NUM_MON        = 17; // monitor events
	localparam int NUM_EVT        = 1 + NUM_EXT + NUM_PROG + NUM_MON; // 151 sources
	localparam int EVT_W          = 8; // event code width
	localparam int PRIO_CPU       = 0; // index of cpu presence
	localparam int PRIO_EXT0      = 1; // index of first trap
	localparam int PRIO_PROG0     = PRIO_EXT0 + NUM_EXT; // index of first programmable
	localparam int PRIO_MON0      = PRIO_PROG0 + NUM_PROG; // index of first monitor
	localparam int CLK_HZ         = 40000000; // system clock rate
	localparam int INSTR_US       = 400; // instruction cycle, us
	localparam int INSTR_CYC      = INSTR_US * (CLK_HZ / 1000000); // 16000 cycles
	localparam int OSC_HZ         = 3000000; // sequencer tick rate
	localparam int OSC_DIV        = (CLK_HZ + OSC_HZ - 1) / OSC_HZ; // 14, tick divider
	localparam int SEC_CYC        = CLK_HZ; // cycles per second
	localparam int ADDR_BITS      = EVT_W; // address bits shifted to flash
	localparam int FIFO_DEPTH     = 32; // event queue depth
	localparam logic [7:0] TMO_RST = 8'h00; // timeout reset value (off)
	localparam int GPIO_W         = 10; // speech pins given to gpio
endpackage

// ==== hw/vwa_fifo.sv ====
`timescale 1ns/10ps
// ***
// event queue fifo
// ***
module vwa_fifo #(
	parameter int WIDTH = 8,  // word width
	parameter int DEPTH = 32  // entries, power of two
) (
	input  wire logic             clk_sys,   // system clock
	input  wire logic             rst_n,     // async reset, active low
	input  wire logic             in_valid,  // write request
	output logic                  in_ready,  // room available
	input  wire logic [WIDTH-1:0] in_data,   // write word
	output logic                  out_valid, // word available
	input  wire logic             out_ready, // reader takes word
	output logic      [WIDTH-1:0] out_data   // head word
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];   // storage
	logic [AW:0]      wr_ff;         // write pointer with wrap bit
	logic [AW:0]      rd_ff;         // read pointer with wrap bit
	logic             push;          // write happens
	logic             pop;           // read happens
	// flags from pointers
	assign out_valid = (wr_ff != rd_ff);
	assign in_ready  = !((wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]));
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ff[AW-1:0]];
	// storage write
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ff[AW-1:0]] <= in_data;
		end
	end
	// pointer update
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ff <= '0;
			rd_ff <= '0;
		end else begin
			if (push) wr_ff <= wr_ff + 1'b1;
			if (pop)  rd_ff <= rd_ff + 1'b1;
		end
	end
endmodule // vwa_fifo

// ==== hw/vwa_flash_if.sv ====
`timescale 1ns/10ps
// ***
// serial flash address driver, strobe only
// ***
module vwa_flash_if
	import vwa_pkg::*;
#(
	parameter int ABITS = ADDR_BITS  // address bits per event
) (
	input  wire logic             clk_sys, // system clock
	input  wire logic             rst_n, // async reset, active low
	input  wire logic             tick, // sequencer tick
	input  wire logic             start, // begin one event
	input  wire logic [ABITS-1:0] code, // event code to send
	output logic                  busy, // transfer running
	output logic                  flash_addr_pulse, // address strobe
	output logic                  flash_shift_clock, // data shift clock
	output logic                  flash_data_out, // serial data
	output logic                  flash_data_oe_n // data drive enable, low drives
);
	initial begin
		if (ABITS < 1 || ABITS > 16) $error("address width out of range");
	end
	logic [ABITS-1:0] sh_ff;     // address shifter
	logic [4:0]       cnt_ff;    // bits remaining
	logic             ph_ff;     // half-bit phase
	logic             run_ff;    // active
	assign busy = run_ff || start;
	// address shift: data set while strobe high, flash latches on falling edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sh_ff            <= '0;
			cnt_ff           <= '0;
			ph_ff            <= 1'b0;
			run_ff           <= 1'b0;
			flash_addr_pulse <= 1'b0;
			flash_data_out   <= 1'b0;
			flash_data_oe_n  <= 1'b1;
		end else if (start && !run_ff) begin
			sh_ff           <= code;
			cnt_ff          <= 5'(ABITS);
			ph_ff           <= 1'b0;
			run_ff          <= 1'b1;
			flash_data_oe_n <= 1'b0;
		end else if (run_ff && tick) begin
			if (!ph_ff && cnt_ff == 5'd0) begin // hold tick past last fall
				run_ff          <= 1'b0;
				flash_data_oe_n <= 1'b1;
			end else if (!ph_ff) begin   // rising half: present bit
				flash_data_out   <= sh_ff[ABITS-1];
				flash_addr_pulse <= 1'b1;
				ph_ff            <= 1'b1;
			end else begin               // falling half: flash latches
				flash_addr_pulse <= 1'b0; // R12
				sh_ff            <= {sh_ff[ABITS-2:0], 1'b0};
				ph_ff            <= 1'b0;
				cnt_ff           <= cnt_ff - 5'd1;
			end
		end
	end
	// shift clock idles low; address phase uses only the strobe
	assign flash_shift_clock = 1'b0; // R13
endmodule // vwa_flash_if

// ==== hw/vwa_arbiter.sv ====
`timescale 1ns/10ps
// Function
// R1 - cpu, traps, programmable, monitor order
// R2 - 151 sources, each its own voice
// R3 - strap sampled after standby reset release
// R4 - gpio pin plain or alternate per pin
// R5 - 0 to 255 second timeout event
// R6 - instruction cycle within 400 us
// R7 - optional early rail failure warning
// R8 - beep separate from voice output
// R9 - sequencer on 3 mhz tick
// R10 - cpu presence low means present
// R11 - traps trigger on rising edge
// R12 - address latched on strobe falling edge
// R13 - data latched on shift clock falling; shift clock here held low, address uses the strobe only
// R14 - losing events stay pending
module vwa_arbiter
	import vwa_pkg::*;
#(
	parameter int INSTR_CYCLES = INSTR_CYC, // play slot length in cycles
	parameter int SEC_CYCLES   = SEC_CYC,   // cycles per second
	parameter int QDEPTH       = FIFO_DEPTH // event queue depth
) (
	input  wire logic                clk_sys, // system clock
	input  wire logic                rst_n, // async reset, active low
	input  wire logic                speech_sel_strap, // strap pin, high gives gpio
	input  wire logic                cpu_presence_in, // low means cpu present
	input  wire logic [NUM_EXT-1:0]  ext_event_trap, // trap pins 1..5
	input  wire logic [NUM_PROG-1:0] prog_event, // programmable events, same clock
	input  wire logic [NUM_MON-1:0]  mon_event, // monitor events, same clock
	input  wire logic [NUM_EVT-1:0]  evt_clear, // clears pending source
	input  wire logic [7:0]          timeout_sec, // 0 disables
	input  wire logic                early_warn_en, // enable rail check
	input  wire logic                vcore_fail, // core rail fail, pin
	input  wire logic                v33_fail, // 3.3 v rail fail, pin
	input  wire logic                beep_req, // beep tone request
	input  wire logic [GPIO_W-1:0]   gpio_alt_sel, // per pin alternate select
	input  wire logic [GPIO_W-1:0]   gpio_out, // gpio output values
	input  wire logic [GPIO_W-1:0]   gpio_dir_out, // gpio output direction
	input  wire logic [GPIO_W-1:0]   gpio_alt_out, // alternate function values
	input  wire logic [GPIO_W-1:0]   gpio_pin_in, // gpio pin levels
	output logic [GPIO_W-1:0]        gpio_pin_out, // gpio pin drive value
	output logic [GPIO_W-1:0]        gpio_pin_oe_n, // low drives pin
	output logic [GPIO_W-1:0]        gpio_in, // synced gpio levels
	output logic                     gpio_mode, // strap result
	output logic                     cpu_present, // synced presence
	output logic                     flash_addr_pulse, // address strobe
	output logic                     flash_shift_clock, // shift clock
	output logic                     flash_data_out, // serial data
	output logic                     flash_data_oe_n, // low drives data
	output logic                     voice_active, // voice slot running
	output logic [EVT_W-1:0]         voice_code, // event being played
	output logic                     beep_out, // beep tone output
	output logic                     timeout_event, // timeout fired pulse
	output logic                     queue_full // queue back pressure
);
	initial begin
		if (INSTR_CYCLES < 1 || SEC_CYCLES < 2 || QDEPTH < 2) $error("bad parameter");
	end
	// ***
	// input synchronisers
	// ***
	localparam int SYW = NUM_EXT + 4 + GPIO_W; // traps, cpu, rails, strap, gpio
	logic [SYW-1:0] sy1_ff;   // first stage only
	logic [SYW-1:0] sy2_ff;   // usable stage
	// two flops for all pin inputs
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sy1_ff <= '0;
			sy2_ff <= '0;
		end else begin
			sy1_ff <= {gpio_pin_in, speech_sel_strap, v33_fail, vcore_fail,
				cpu_presence_in, ext_event_trap};
			sy2_ff <= sy1_ff;
		end
	end
	logic [NUM_EXT-1:0] trap_s;   // synced traps
	logic               cpu_abs_s; // synced presence, high absent
	logic               vc_s;     // synced core fail
	logic               v33_s;    // synced 3.3 fail
	logic               strap_s;  // synced strap
	assign trap_s    = sy2_ff[NUM_EXT-1:0];
	assign cpu_abs_s = sy2_ff[NUM_EXT];
	assign vc_s      = sy2_ff[NUM_EXT+1];
	assign v33_s     = sy2_ff[NUM_EXT+2];
	assign strap_s   = sy2_ff[NUM_EXT+3];
	assign gpio_in   = sy2_ff[SYW-1 -: GPIO_W];
	assign cpu_present = !cpu_abs_s; // R10
	// ***
	// strap capture
	// ***
	logic [1:0] strap_wait_ff; // waits for sync pipe to fill
	logic       gpio_mode_ff;  // latched strap
	// sample once, after reset release settles
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strap_wait_ff <= 2'h0;
			gpio_mode_ff  <= 1'b0;
		end else if (strap_wait_ff != 2'h3) begin
			strap_wait_ff <= strap_wait_ff + 2'h1;
			if (strap_wait_ff == 2'h2) gpio_mode_ff <= strap_s; // R3
		end
	end
	assign gpio_mode = gpio_mode_ff;
	logic spk_en; // strap known and speech mode
	assign spk_en = (strap_wait_ff == 2'h3) && !gpio_mode_ff; // R3
	// ***
	// 3 mhz tick and second counter
	// ***
	logic [4:0]  div_ff;  // oscillator divider
	logic        tick;    // sequencer enable
	assign tick = (div_ff == 5'(OSC_DIV - 1));
	// divider for sequencer tick
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) div_ff <= 5'h00;
		else if (tick) div_ff <= 5'h00; // R9
		else div_ff <= div_ff + 5'h01;
	end
	logic [31:0] sec_ff;   // cycle count in a second
	logic [7:0]  tsec_ff;  // elapsed seconds
	logic        tmo_done_ff; // fired once per programming
	// timeout counter, restarts when value changes
	logic [7:0]  tprev_ff; // last programmed value
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sec_ff      <= '0;
			tsec_ff     <= TMO_RST;
			tprev_ff    <= TMO_RST;
			tmo_done_ff <= 1'b0;
			timeout_event <= 1'b0;
		end else begin
			timeout_event <= 1'b0;
			tprev_ff <= timeout_sec;
			if (timeout_sec != tprev_ff) begin
				sec_ff <= '0;
				tsec_ff <= 8'h00;
				tmo_done_ff <= 1'b0;
			end else if (timeout_sec != 8'h00 && !tmo_done_ff) begin
				if (sec_ff == 32'(SEC_CYCLES - 1)) begin
					sec_ff <= '0;
					if (tsec_ff + 8'h01 == timeout_sec) begin
						timeout_event <= 1'b1; // R5
						tmo_done_ff <= 1'b1;
					end
					tsec_ff <= tsec_ff + 8'h01;
				end else begin
					sec_ff <= sec_ff + 32'd1;
				end
			end
		end
	end
	// ***
	// pending event flags
	// ***
	logic [NUM_EXT-1:0] trap_d_ff; // trap previous level
	logic               cpu_d_ff;  // presence previous level
	logic               rail_d_ff; // rail fail previous
	logic [NUM_EVT-1:0] pend_ff;   // pending sources
	logic [NUM_EVT-1:0] set_v;     // new events this cycle
	logic [NUM_EVT-1:0] take_v;    // one-hot of served source
	logic               rail_fail; // combined rail failure
	assign rail_fail = early_warn_en && (vc_s || v33_s); // R7
	// edge history
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			trap_d_ff <= '0;
			cpu_d_ff  <= 1'b0;
			rail_d_ff <= 1'b0;
		end else begin
			trap_d_ff <= trap_s;
			cpu_d_ff  <= cpu_abs_s;
			rail_d_ff <= rail_fail;
		end
	end
	// event sources: cpu change, trap rise, timeout on first programmable slot
	always_comb begin
		set_v = '0;
		set_v[PRIO_CPU] = (cpu_abs_s != cpu_d_ff) || (rail_fail && !rail_d_ff);
		set_v[PRIO_EXT0 +: NUM_EXT] = trap_s & ~trap_d_ff; // R11
		set_v[PRIO_PROG0 +: NUM_PROG] = prog_event;
		set_v[PRIO_PROG0] = prog_event[0] || timeout_event;
		set_v[PRIO_MON0 +: NUM_MON] = mon_event; // R2
	end
	// set beats clear; served source drops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) pend_ff <= '0;
		else pend_ff <= set_v | (pend_ff & ~evt_clear & ~take_v); // R14
	end
	// ***
	// priority pick and queue
	// ***
	logic             q_in_ready; // queue room
	logic [EVT_W-1:0] pick;     // lowest index pending
	logic             pick_vld; // any pending
	// lowest index wins
	always_comb begin
		pick = '0;
		pick_vld = 1'b0;
		take_v = '0;
		for (int i = NUM_EVT - 1; i >= 0; i--) begin
			if (pend_ff[i]) begin
				pick = EVT_W'(i); // R1
				pick_vld = 1'b1;
			end
		end
		if (pick_vld && q_in_ready && spk_en) take_v[pick] = 1'b1;
	end
	logic             q_out_valid; // queued event
	logic             q_out_ready; // sequencer takes
	logic [EVT_W-1:0] q_out_data;  // queued code
	assign queue_full = !q_in_ready;
	vwa_fifo #(.WIDTH(EVT_W), .DEPTH(QDEPTH)) u_queue (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_valid  (pick_vld && spk_en),
		.in_ready  (q_in_ready),
		.in_data   (pick),
		.out_valid (q_out_valid),
		.out_ready (q_out_ready),
		.out_data  (q_out_data)
	);
	// ***
	// voice sequencer
	// ***
	typedef enum logic [1:0] {VS_IDLE, VS_ADDR, VS_PLAY} vwa_vs_e;
	vwa_vs_e     vs_ff;   // sequencer state
	logic [31:0] slot_ff; // play slot counter
	logic        fl_busy; // flash driver busy
	assign q_out_ready = (vs_ff == VS_IDLE);
	assign voice_active = (vs_ff != VS_IDLE);
	// one event at a time, next waits until play ends
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			vs_ff      <= VS_IDLE;
			slot_ff    <= '0;
			voice_code <= '0;
		end else begin
			case (vs_ff)
				VS_IDLE: begin
					if (q_out_valid) begin
						voice_code <= q_out_data;
						vs_ff      <= VS_ADDR;
					end
				end
				VS_ADDR: begin
					if (!fl_busy) begin
						slot_ff <= '0;
						vs_ff   <= VS_PLAY;
					end
				end
				VS_PLAY: begin
					if (slot_ff == 32'(INSTR_CYCLES - 1)) vs_ff <= VS_IDLE; // R6
					else slot_ff <= slot_ff + 32'd1;
				end
				default: vs_ff <= VS_IDLE;
			endcase
		end
	end
	logic fl_addr;  // driver strobe
	logic fl_clk;   // driver shift clock
	logic fl_dat;   // driver data
	logic fl_oen;   // driver enable
	vwa_flash_if #(.ABITS(EVT_W)) u_flash (
		.clk_sys           (clk_sys),
		.rst_n             (rst_n),
		.tick              (tick),
		.start             (vs_ff == VS_IDLE && q_out_valid),
		.code              (q_out_data),
		.busy              (fl_busy),
		.flash_addr_pulse  (fl_addr),
		.flash_shift_clock (fl_clk),
		.flash_data_out    (fl_dat),
		.flash_data_oe_n   (fl_oen)
	);
	// speech pins quiet in gpio mode
	assign flash_addr_pulse  = fl_addr && !gpio_mode_ff;
	assign flash_shift_clock = fl_clk && !gpio_mode_ff;
	assign flash_data_out    = fl_dat && !gpio_mode_ff;
	assign flash_data_oe_n   = fl_oen || gpio_mode_ff;
	// ***
	// beep and gpio
	// ***
	logic [7:0] bdiv_ff; // beep tone divider
	logic       tone_ff; // tone square wave
	// beep tone independent of the voice path
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bdiv_ff <= 8'h00;
			tone_ff <= 1'b0;
		end else if (tick) begin
			bdiv_ff <= bdiv_ff + 8'h01;
			if (bdiv_ff == 8'hff) tone_ff <= !tone_ff;
		end
	end
	assign beep_out = (beep_req || rail_fail) && tone_ff; // R8
	// per pin gpio mux
	for (genvar g = 0; g < GPIO_W; g++) begin : g_gpio
		assign gpio_pin_out[g] = gpio_alt_sel[g] ? gpio_alt_out[g] : gpio_out[g]; // R4
		assign gpio_pin_oe_n[g] = !(gpio_mode_ff && (gpio_alt_sel[g] || gpio_dir_out[g]));
	end
endmodule // vwa_arbiter

// ==== bench/vwa_flash_model.sv ====
`timescale 1ns/10ps
// ***
// serial voice flash, address side
// ***
module vwa_flash_model (
	input  wire logic  flash_addr_pulse,  // address strobe from arbiter
	input  wire logic  flash_shift_clock, // data shift clock from arbiter
	input  wire logic  flash_data_out,    // serial data from arbiter
	input  wire logic  flash_data_oe_n,   // low while arbiter drives data
	output int         code_cnt,          // complete addresses received
	output logic [7:0] code,              // last complete address
	output int         rd_clk_cnt         // data clocks seen
);
	logic       last_ff;   // last level seen on the data line
	logic [7:0] shift_ff;  // speech address counter input
	int         nbits_ff;  // bits latched in this frame
	wire        data_line; // resolved data wire

	// released line shows no stale level
	assign data_line = flash_data_oe_n ? ~last_ff : flash_data_out;

	initial begin
		code_cnt = 0;
		rd_clk_cnt = 0;
		nbits_ff = 0;
		last_ff = 1'b0;
	end

	// address bit latched on strobe falling edge, msb first
	always @(negedge flash_addr_pulse) begin
		if (flash_data_oe_n === 1'b0) begin
			shift_ff = {shift_ff[6:0], data_line};
			last_ff = data_line;
			nbits_ff++;
			if (nbits_ff == 8) begin
				code = shift_ff;
				code_cnt++;
				nbits_ff = 0;
			end
		end
	end

	// frame end drops a partial address
	always @(posedge flash_data_oe_n) begin
		nbits_ff = 0;
	end

	// data latched on shift clock falling edge
	always @(negedge flash_shift_clock) begin
		if (flash_data_oe_n === 1'b0) begin
			rd_clk_cnt++;
		end
	end
endmodule // vwa_flash_model

// ==== bench/vwa_arbiter_sva.sv ====
`timescale 1ns/10ps
// ***
// arbiter port checker
// ***
module vwa_arbiter_sva #(
	parameter int INSTR_CYCLES = vwa_pkg::INSTR_CYC // play slot length
) (
	input wire logic                      clk_sys,           // system clock
	input wire logic                      rst_n,             // async reset, active low
	input wire logic                      cpu_presence_in,   // low means present
	input wire logic [7:0]                timeout_sec,       // 0 disables
	input wire logic [vwa_pkg::GPIO_W-1:0] gpio_alt_sel,     // alternate select
	input wire logic [vwa_pkg::GPIO_W-1:0] gpio_out,         // plain values
	input wire logic [vwa_pkg::GPIO_W-1:0] gpio_alt_out,     // alternate values
	input wire logic [vwa_pkg::GPIO_W-1:0] gpio_pin_out,     // pin drive value
	input wire logic [vwa_pkg::GPIO_W-1:0] gpio_pin_oe_n,    // low drives
	input wire logic                      gpio_mode,         // strap result
	input wire logic                      cpu_present,       // synced presence
	input wire logic                      flash_addr_pulse,  // address strobe
	input wire logic                      flash_shift_clock, // shift clock
	input wire logic                      flash_data_out,    // serial data
	input wire logic                      flash_data_oe_n,   // low drives data
	input wire logic                      voice_active,      // slot running
	input wire logic [vwa_pkg::EVT_W-1:0]  voice_code,       // event played
	input wire logic                      timeout_event,     // timeout pulse
	input wire logic                      queue_full         // queue full
);
	import vwa_pkg::*;
	localparam int LEN_MIN = INSTR_CYCLES + 210; // address shift plus play, short
	localparam int LEN_MAX = INSTR_CYCLES + 260; // address shift plus play, long
	int len_ff; // cycles of the running voice slot

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// ***
	// slot length counter
	// ***
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			len_ff <= 0;
		end else begin
			len_ff <= voice_active ? len_ff + 1 : 0;
		end
	end

	// ***
	// assertions
	// ***
	slot_len_a:
	assert property ($fell(voice_active) |-> len_ff >= LEN_MIN && len_ff <= LEN_MAX)
		else $error("slot length wrong");
	addr_drive_a:
	assert property (flash_addr_pulse |-> !flash_data_oe_n)
		else $error("address strobe while data released");
	data_hold_a:
	assert property ($fell(flash_addr_pulse) |-> $stable(flash_data_out))
		else $error("data moved at strobe fall");
	strobe_width_a:
	assert property ($rose(flash_addr_pulse) |-> flash_addr_pulse [*8])
		else $error("strobe too short");
	slot_start_a:
	assert property ($rose(voice_active) |-> ##[0:2] !flash_data_oe_n)
		else $error("slot without address");
	code_hold_a:
	assert property (voice_active && $past(voice_active) |-> $stable(voice_code))
		else $error("voice code changed in a slot");
	tmo_pulse_a:
	assert property (timeout_event |=> !timeout_event)
		else $error("timeout pulse too long");
	tmo_off_a:
	assert property (timeout_event |-> timeout_sec != 8'h00)
		else $error("timeout fired while disabled");
	cpu_absent_a:
	assert property (cpu_presence_in [*6] |-> !cpu_present)
		else $error("absent cpu reported present");
	cpu_here_a:
	assert property (!cpu_presence_in [*6] |-> cpu_present)
		else $error("present cpu reported absent");
	gpio_quiet_a:
	assert property (gpio_mode |-> !voice_active && !flash_addr_pulse)
		else $error("speech activity in gpio mode");
	gpio_oe_a:
	assert property (!gpio_mode |-> &gpio_pin_oe_n)
		else $error("gpio pin driven in speech mode");
	gpio_mux_a:
	assert property (gpio_mode |-> gpio_pin_out ==
		((gpio_alt_sel & gpio_alt_out) | (~gpio_alt_sel & gpio_out)))
		else $error("gpio pin value wrong");
	shift_idle_a:
	assert property (!flash_shift_clock)
		else $error("shift clock moved");

	cover property ($fell(voice_active));
	cover property ($rose(queue_full));
	cover property (timeout_event);
	cover property ($rose(gpio_mode));
endmodule // vwa_arbiter_sva

bind vwa_arbiter vwa_arbiter_sva #(.INSTR_CYCLES(INSTR_CYCLES)) u_sva (
	.clk_sys, .rst_n, .cpu_presence_in, .timeout_sec, .gpio_alt_sel, .gpio_out,
	.gpio_alt_out, .gpio_pin_out, .gpio_pin_oe_n, .gpio_mode, .cpu_present,
	.flash_addr_pulse, .flash_shift_clock, .flash_data_out, .flash_data_oe_n,
	.voice_active, .voice_code, .timeout_event, .queue_full
);

// ==== bench/tb.sv ====
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin bad_count++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module tb;
	import vwa_pkg::*;
	localparam int SEC_T = 100; // shortened second
	logic                clk_sys = 1'b0, rst_n = 1'b0, link_clk = 1'b0;
	logic                speech_sel_strap = 1'b0, cpu_presence_in = 1'b0;
	logic [NUM_EXT-1:0]  ext_event_trap = '0;
	logic [NUM_PROG-1:0] prog_event = '0, pv;
	logic [NUM_MON-1:0]  mon_event = '0, mv;
	logic [NUM_EVT-1:0]  evt_clear = '0;
	logic [7:0]          timeout_sec = 8'h00, fl_code;
	logic                early_warn_en = 1'b0, vcore_fail = 1'b0, v33_fail = 1'b0;
	logic                beep_req = 1'b0, gpio_mode, cpu_present, flash_addr_pulse;
	logic [GPIO_W-1:0]   gpio_alt_sel = '0, gpio_out = '0, gpio_dir_out = '0;
	logic [GPIO_W-1:0]   gpio_alt_out = '0, gpio_pins = '0, gpio_pin_in;
	logic [GPIO_W-1:0]   gpio_pin_out, gpio_pin_oe_n, gpio_in;
	logic                flash_shift_clock, flash_data_out, flash_data_oe_n;
	logic                voice_active, beep_out, timeout_event, queue_full;
	logic [EVT_W-1:0]    voice_code;
	int                  bad_count = 0, comparisons = 0, seed = 20033;
	int                  exp_q[$], seen_cnt = 0, fl_cnt, rd_cnt, e_code, n;

	always #12.5 clk_sys = ~clk_sys; // 40 mhz
	always #100 link_clk = ~link_clk; // unrelated pin clock
	assign gpio_pin_in = {link_clk, gpio_pins[8:0]};

	vwa_arbiter #(.INSTR_CYCLES(50), .SEC_CYCLES(SEC_T), .QDEPTH(FIFO_DEPTH)) dut (
		.clk_sys, .rst_n, .speech_sel_strap, .cpu_presence_in, .ext_event_trap,
		.prog_event, .mon_event, .evt_clear, .timeout_sec, .early_warn_en, .vcore_fail,
		.v33_fail, .beep_req, .gpio_alt_sel, .gpio_out, .gpio_dir_out, .gpio_alt_out,
		.gpio_pin_in, .gpio_pin_out, .gpio_pin_oe_n, .gpio_in, .gpio_mode, .cpu_present,
		.flash_addr_pulse, .flash_shift_clock, .flash_data_out, .flash_data_oe_n,
		.voice_active, .voice_code, .beep_out, .timeout_event, .queue_full);
	vwa_flash_model u_flash (.flash_addr_pulse, .flash_shift_clock, .flash_data_out,
		.flash_data_oe_n, .code_cnt(fl_cnt), .code(fl_code), .rd_clk_cnt(rd_cnt));

	// ***
	// helpers
	// ***
	task automatic tick(int k);
		repeat (k) @(posedge clk_sys);
	endtask
	task automatic do_reset();
		@(posedge clk_sys) rst_n <= 1'b0;
		tick(2);
		rst_n <= 1'b1;
		tick(4);
	endtask
	// wait for empty model queue and idle slot
	task automatic drain();
		n = 0;
		while ((exp_q.size() != 0 || voice_active !== 1'b0) && n < 60000) begin
			@(negedge clk_sys);
			n++;
		end
		`CHK("events left", 0, exp_q.size())
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// flash address against model
	always @(negedge clk_sys) begin
		if (fl_cnt != seen_cnt) begin
			seen_cnt = fl_cnt;
			e_code = (exp_q.size() != 0) ? exp_q.pop_front() : 255;
			`CHK("flash address", e_code[7:0], fl_code)
			`CHK("voice code", e_code[7:0], voice_code)
		end
	end

	initial begin
		#2500000;
		bad_count++;
		report_and_stop();
	end

	// ***
	// scenarios
	// ***
	initial begin
		do_reset();
		@(negedge clk_sys);
		`CHK("gpio mode", 1'b0, gpio_mode)
		`CHK("cpu present", 1'b1, cpu_present)
		// presence change and three traps together
		@(posedge clk_sys);
		cpu_presence_in <= 1'b1;
		ext_event_trap <= 5'h15;
		exp_q = '{PRIO_CPU, PRIO_EXT0, PRIO_EXT0 + 2, PRIO_EXT0 + 4};
		tick(5);
		@(negedge clk_sys);
		`CHK("cpu absent", 1'b0, cpu_present)
		@(posedge clk_sys) ext_event_trap <= 5'h00; // falling edges raise nothing
		drain();
		@(posedge clk_sys) cpu_presence_in <= 1'b0;
		exp_q.push_back(PRIO_CPU);
		drain();
		// each rail failure raises the early warning
		early_warn_en <= 1'b1;
		for (int r = 0; r < 2; r++) begin
			@(posedge clk_sys) {v33_fail, vcore_fail} <= 2'b01 << r;
			exp_q.push_back(PRIO_CPU);
			drain();
			@(posedge clk_sys) {v33_fail, vcore_fail} <= 2'b00; // failed rail clears
		end
		// two second timeout
		@(posedge clk_sys) timeout_sec <= 8'h02;
		n = 0;
		while (timeout_event !== 1'b1 && n < 1000) begin
			@(negedge clk_sys);
			n++;
		end
		`CHK("timeout delay", 1'b1, n >= 2 * SEC_T - 5 && n <= 2 * SEC_T + 5)
		@(posedge clk_sys) timeout_sec <= 8'h00;
		exp_q.push_back(PRIO_PROG0);
		drain();
		// beep tone runs without any voice slot
		@(posedge clk_sys) beep_req <= 1'b1;
		for (int lv = 1; lv >= 0; lv--) begin
			n = 0;
			while (beep_out !== lv[0] && n < 8000) begin
				@(negedge clk_sys);
				n++;
			end
			`CHK("beep level", lv[0], beep_out)
			`CHK("voice idle", 1'b0, voice_active)
		end
		beep_req <= 1'b0;
		// random burst overflows the queue; last monitor event withdrawn
		pv = {$random(seed), $random(seed), $random(seed), $random(seed)};
		mv = NUM_MON'($random(seed));
		mv[16] = 1'b1;
		for (int i = 0; i < NUM_PROG; i++) if (pv[i]) exp_q.push_back(PRIO_PROG0 + i);
		for (int j = 0; j < 16; j++) if (mv[j]) exp_q.push_back(PRIO_MON0 + j);
		@(posedge clk_sys);
		prog_event <= pv;
		mon_event <= mv;
		@(posedge clk_sys);
		prog_event <= '0;
		mon_event <= '0;
		tick(40);
		@(negedge clk_sys);
		`CHK("queue full", 1'b1, queue_full)
		@(posedge clk_sys) evt_clear <= NUM_EVT'(1) << (PRIO_MON0 + 16);
		@(posedge clk_sys) evt_clear <= '0;
		drain();
		// strap high at power-up: gpio
		speech_sel_strap <= 1'b1;
		do_reset();
		@(posedge clk_sys);
		gpio_alt_sel <= GPIO_W'($random(seed));
		gpio_out <= GPIO_W'($random(seed));
		gpio_dir_out <= GPIO_W'($random(seed));
		gpio_alt_out <= GPIO_W'($random(seed));
		gpio_pins <= GPIO_W'($random(seed));
		prog_event <= 128'h1;
		@(posedge clk_sys) prog_event <= '0;
		tick(600);
		@(negedge clk_sys);
		`CHK("gpio mode", 1'b1, gpio_mode)
		`CHK("gpio drive", (gpio_alt_sel & gpio_alt_out) | (~gpio_alt_sel & gpio_out), gpio_pin_out)
		`CHK("gpio enable", ~gpio_dir_out | gpio_alt_sel, gpio_pin_oe_n | gpio_alt_sel)
		`CHK("gpio input", gpio_pins[8:0], gpio_in[8:0])
		`CHK("voice refused", 1'b0, voice_active)
		@(posedge clk_sys) speech_sel_strap <= 1'b0;
		tick(5);
		@(negedge clk_sys);
		`CHK("strap kept", 1'b1, gpio_mode)
		`CHK("data clocks", 0, rd_cnt)
		report_and_stop();
	end
endmodule // tb
